// File: tb/eba_area_config_checker.sv
// eba_area_config_checker: port-level properties of the area block
// assumes binding onto eba_area_config, one clk_sys domain
`timescale 1ns/1ns
module eba_area_config_checker (
  input logic        clk_sys,
  input logic        rst_n,
  input logic        acc_valid,
  input logic [31:0] acc_addr,
  input logic [6:0]  area_select,
  input logic        area_card,
  input logic [1:0]  area_burst,
  input logic        area_sdram,
  input logic        card_a_upper_enable,
  input logic        card_b_upper_enable,
  input logic        addr_pullup_en,
  input logic        data_pullup_en,
  input logic        dyn_sizing_en,
  input logic        little_endian
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire [2:0] fld = acc_addr[28:26];
  wire       any = area_select != 7'h00;

  sequence s_pull4;
    addr_pullup_en [*4] ##1 !addr_pullup_en;
  endsequence

  a_area_decode:
    assert property (acc_valid && fld != 3'h1 && fld != 3'h7
      |=> area_select == 7'h01 << $past(fld)) else $error("bad select");
  a_no_area:
    assert property (acc_valid && fld inside {3'h1, 3'h7}
      |=> area_select == 7'h00) else $error("reserved area selected");
  a_pull_four:
    assert property ($rose(addr_pullup_en) |-> s_pull4)
      else $error("address pull-up not four cycles");
  a_bus_busy:
    assert property (acc_valid |=> !data_pullup_en)
      else $error("data pull-up while bus busy");
  a_card_a:
    assert property (card_a_upper_enable |-> area_select[5] && area_card)
      else $error("card a enable outside area 5");
  a_card_b:
    assert property (card_b_upper_enable |-> area_select[6] && area_card)
      else $error("card b enable outside area 6");
  a_dyn_le:
    assert property (dyn_sizing_en |-> little_endian)
      else $error("dynamic sizing in big endian");
  a_sdram_area:
    assert property (area_sdram && any |-> area_select[3:2] != 2'h0)
      else $error("sdram outside areas 2 and 3");
  a_burst_area:
    assert property (area_burst != 2'h0 && any
      |-> area_select[0] || area_select[5] || area_select[6])
      else $error("burst outside areas 0, 5, 6");
endmodule : eba_area_config_checker

bind eba_area_config eba_area_config_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .acc_valid(acc_valid),
  .acc_addr(acc_addr), .area_select(area_select), .area_card(area_card),
  .area_burst(area_burst), .area_sdram(area_sdram),
  .card_a_upper_enable(card_a_upper_enable),
  .card_b_upper_enable(card_b_upper_enable),
  .addr_pullup_en(addr_pullup_en), .data_pullup_en(data_pullup_en),
  .dyn_sizing_en(dyn_sizing_en), .little_endian(little_endian));

// File: tb/eba_area_config_tb.sv
// eba_area_config_tb: apb and decode sequences with expected values
// assumes the design package and the card model are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  error_cnt++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); \
  end end
module eba_area_config_tb;
  import eba_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] acc_addr = 32'h0;
  logic [1:0]  strap = 2'h2;
  logic        bo = 1'b1, av = 1'b0, rel = 1'b0, stby = 1'b0;
  logic [31:0] prdata, rd;
  logic [6:0]  sel;
  logic [1:0]  wid, bst;
  logic        pready, pslverr, er, crd, sd, cea, ceb, apu, dpu;
  logic        coe, cdh, soe, dyn, le, bad, io16;
  logic [15:0] cfg;
  logic [3:0]  be = 4'h1;
  // upper data lanes stay a bus, so longword widths are allowed
  logic [15:0] wc = 16'h17a0;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cnt;

  always #25 clk_sys = ~clk_sys;

  eba_area_config dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .width_strap_hi(strap[1]), .width_strap_lo(strap[0]),
    .byte_order_strap(bo), .acc_valid(av), .acc_addr(acc_addr),
    .acc_byte_en(be), .card_io16(io16), .bus_release_ack(rel),
    .standby(stby), .area_select(sel), .area_width(wid), .area_card(crd),
    .area_burst(bst), .area_sdram(sd), .card_a_upper_enable(cea),
    .card_b_upper_enable(ceb), .addr_pullup_en(apu), .data_pullup_en(dpu),
    .ctl_pins_oe(coe), .ctl_pins_drive_high(cdh), .strobe_pins_oe(soe),
    .dyn_sizing_en(dyn), .little_endian(le), .strap_illegal(bad));
  eba_ext_dev u_dev (.area_select(sel), .card_io16(io16));

  task final_report;
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task reset_dut(input logic [1:0] w, input logic b);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    strap <= w;
    bo <= b;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : reset_dut

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      error_cnt++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial
  begin
    reset_dut(2'h2, 1'b1);
    apb(0, OFS_AREA_CFG, 0); `CHK(rd, 32'h0000_0800)
    apb(0, OFS_WIDTH_CFG, 0); `CHK(rd, 32'h0000_3ff0)
    apb(0, OFS_STATUS, 0); `CHK(rd[3:0], 4'h6)
    apb(1, OFS_AREA_CFG, 32'hffff_ffff);
    apb(0, OFS_AREA_CFG, 0); `CHK(rd, 32'h0000_ffff)
    apb(1, OFS_AREA_CFG, 0);
    apb(0, OFS_AREA_CFG, 0); `CHK(rd, 32'h0000_0800)
    apb(1, 8'h0c, 32'hffff); `CHK(er, 1'b1)
    apb(0, 8'h0c, 0); `CHK({er, rd}, {1'b1, 32'h0})
    apb(1, OFS_WIDTH_CFG, {16'h0, wc});
    for (int c = 0; c < 3; c++)
    begin
      cfg = (c == 2) ? 16'h0003 : c ? 16'h0369 : 16'h036e;
      // sdram codes assume the core clock runs faster than the bus
      apb(1, OFS_AREA_CFG, {16'h0, cfg});
      // area 7 and its shadows are reserved, so never presented
      for (int a = 0; a < 7; a++)
      begin
        @(posedge clk_sys);
        av <= 1'b1;
        acc_addr <= {a[2:0], a[2:0], 26'h0};
        be <= {2'h0, a[0] ^ c[0], 1'b1};
        @(posedge clk_sys);
        av <= 1'b0;
        #1;
        `CHK(sel, (a == 1 || a == 7) ? 7'h0 : 7'h01 << a)
        if (a != 1 && a != 7)
        begin
          `CHK(wid, a == 0 ? 2'h2 : wc[2*a +: 2])
          `CHK(bst, a == 0 ? cfg[10:9] : a == 5 ? cfg[8:7] :
            a == 6 ? cfg[6:5] : 2'h0)
          `CHK(sd, (a == 3 && cfg[3]) || (a == 2 && cfg[2]))
          `CHK({crd, cea, ceb}, {(a == 5 && cfg[1]) || (a == 6 && cfg[0]),
            a == 5 && cfg[1] && be[1],
            a == 6 && cfg[0] && be[1]})
        end
        // card io16 answers the registered select, sizing a cycle later
        @(posedge clk_sys);
        #1;
        `CHK(dyn, bo && ((a == 5 && cfg[1]) || (a == 6 && cfg[0])))
      end
    end
    for (int v = 0; v < 2; v++)
    begin
      apb(1, OFS_AREA_CFG, {16'h0, v[0], 15'h0});
      @(posedge clk_sys);
      rel <= 1'b1;
      cnt = 0;
      repeat (12)
      begin
        @(posedge clk_sys);
        #1;
        cnt += (apu === 1'b1);
      end
      `CHK(cnt, v * 4)
      `CHK(soe, 1'b0)
      @(posedge clk_sys);
      rel <= 1'b0;
      // stby and pull-up share the bit word, so one write per value
      apb(1, OFS_AREA_CFG, {16'h0, 2'h1, v[0], v[0], 12'h0});
      @(posedge clk_sys);
      stby <= 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      `CHK({coe, cdh, soe}, {v[0], v[0], v[0]})
      `CHK(dpu, 1'b1)
      @(posedge clk_sys);
      stby <= 1'b0;
    end
    reset_dut(2'h0, 1'b0);
    @(posedge clk_sys);
    #1;
    `CHK({bad, le}, 2'h2)
    apb(0, OFS_AREA_CFG, 0); `CHK(rd, 32'h0)
    final_report();
  end
endmodule : eba_area_config_tb

// File: tb/eba_ext_dev.sv
// eba_ext_dev: far-side card model answering 16-bit i/o
// assumes area_select one-hot from the block on clk_sys
`timescale 1ns/1ns
module eba_ext_dev (
  input  wire logic [6:0] area_select,
  output wire logic       card_io16
);
  // a card only speaks while its own select is seen
  assign card_io16 = area_select[5] | area_select[6];
endmodule : eba_ext_dev

// File: verilog/eba_area_config.sv
// eba_area_config: area decode, bus width and primary configuration
// assumes apb master on clk_sys; strap pins asynchronous, bus-release and
// standby levels are asynchronous pins too
`timescale 1ns/1ns

module eba_area_config
  import eba_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        width_strap_hi,
  input  wire logic        width_strap_lo,
  input  wire logic        byte_order_strap,
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic [3:0]  acc_byte_en,
  input  wire logic        card_io16,
  input  wire logic        bus_release_ack,
  input  wire logic        standby,
  output logic      [6:0]  area_select,
  output logic      [1:0]  area_width,
  output logic             area_card,
  output logic      [1:0]  area_burst,
  output logic             area_sdram,
  output logic             card_a_upper_enable,
  output logic             card_b_upper_enable,
  output logic             addr_pullup_en,
  output logic             data_pullup_en,
  output logic             ctl_pins_oe,
  output logic             ctl_pins_drive_high,
  output logic             strobe_pins_oe,
  output logic             dyn_sizing_en,
  output logic             little_endian,
  output logic             strap_illegal
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       strap_taken;
  logic [1:0] area0_width;
  logic       release_q;
  logic [2:0] pull_cnt;
  logic [1:0] sync_fill;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_fill <= 2'h0;
    end
    else
    begin
      sync_a <= {width_strap_hi, width_strap_lo, byte_order_strap,
                 bus_release_ack, standby};
      sync_b <= sync_a;
      // two edges until sync_b carries a sampled pin level
      if (sync_fill != 2'h2)
        sync_fill <= sync_fill + 2'h1;
    end
  end

  wire logic s_hi    = sync_b[4];
  wire logic s_lo    = sync_b[3];
  wire logic s_endn  = sync_b[2];
  wire logic s_rel   = sync_b[1];
  wire logic s_stby  = sync_b[0];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [15:0] bus_area_config;
  logic [15:0] area_width_config;

  wire logic wr_en = psel && penable && pwrite;
  wire logic addr_ok = (paddr == OFS_AREA_CFG) ||
                       (paddr == OFS_WIDTH_CFG) ||
                       (paddr == OFS_STATUS);

  // straps caught once, as soon as the synchroniser has filled;
  // only the second stage is read, the first may still be settling
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      strap_taken <= 1'b0;
      area0_width <= 2'h0;
    end
    else if (!strap_taken && sync_fill == 2'h2)
    begin
      strap_taken <= 1'b1;
      area0_width <= {s_hi, s_lo};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bus_area_config <= AREA_CFG_RST;
    else
    begin
      if (wr_en && paddr == OFS_AREA_CFG)
        bus_area_config <= (pwdata[15:0] & AREA_CFG_WMASK) |
                           (bus_area_config & ~AREA_CFG_WMASK);
      if (!strap_taken)
        bus_area_config[B_ENDIAN] <= s_endn;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      area_width_config <= WIDTH_CFG_RST;
    else if (wr_en && paddr == OFS_WIDTH_CFG)
      area_width_config <= pwdata[15:0] & WIDTH_CFG_WMASK;
  end

  // zero-wait slave; unmapped addresses answer with pslverr
  always_comb
  begin
    pready  = 1'b1;
    pslverr = psel && penable && !addr_ok;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFS_AREA_CFG:  prdata <= {16'h0000, bus_area_config};
        OFS_WIDTH_CFG: prdata <= {16'h0000, area_width_config};
        OFS_STATUS:    prdata <= {28'h0000000, strap_illegal,
                                  strap_taken, area0_width};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // area decode
  // ----------------------------------------------------------------------
  // bits 31:29 never looked at, so shadows alias automatically
  wire logic [2:0] area_num = acc_addr[28:26];
  wire logic [2:0] mem_type = bus_area_config[B_MEM_TYPE +: 3];
  wire logic a5_card = bus_area_config[B_A5_CARD];
  wire logic a6_card = bus_area_config[B_A6_CARD];
  logic [1:0] next_width;
  logic       next_card;
  logic [1:0] next_burst;
  logic       next_sdram;
  logic [6:0] next_sel;

  always_comb
  begin
    next_sel   = 7'h00;
    next_width = 2'h0;
    next_card  = 1'b0;
    next_burst = 2'h0;
    next_sdram = 1'b0;
    // area 1 is internal i/o and area 7 reserved: no select
    if (acc_valid && area_num <= AREA_LAST && area_num != AREA_NONE)
      next_sel[area_num] = 1'b1;
    unique case (area_num)
      3'h0:
      begin
        next_width = area0_width;
        next_burst = bus_area_config[B_A0_BST +: 2];
      end
      3'h2:
      begin
        next_width = area_width_config[5:4];
        next_sdram = (mem_type == MT_BOTH_SD);
      end
      3'h3:
      begin
        next_width = area_width_config[7:6];
        next_sdram = (mem_type == MT_BOTH_SD) ||
                     (mem_type == MT_A3_SDRAM);
      end
      3'h4:
        next_width = area_width_config[9:8];
      3'h5:
      begin
        next_width = area_width_config[11:10];
        next_card  = a5_card;
        next_burst = bus_area_config[B_A5_BST +: 2];
      end
      3'h6:
      begin
        next_width = area_width_config[13:12];
        next_card  = a6_card;
        next_burst = bus_area_config[B_A6_BST +: 2];
      end
      default:
        next_width = 2'h0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      area_select <= 7'h00;
      area_width  <= 2'h0;
      area_card   <= 1'b0;
      area_burst  <= 2'h0;
      area_sdram  <= 1'b0;
      card_a_upper_enable <= 1'b0;
      card_b_upper_enable <= 1'b0;
    end
    else
    begin
      area_select <= next_sel;
      area_width  <= next_width;
      area_card   <= next_card && |next_sel;
      area_burst  <= next_burst;
      area_sdram  <= next_sdram && |next_sel;
      // upper card enable covers the odd byte lane of a card access
      card_a_upper_enable <= next_sel[5] && a5_card &&
                             acc_byte_en[1];
      card_b_upper_enable <= next_sel[6] && a6_card &&
                             acc_byte_en[1];
    end
  end

  // ----------------------------------------------------------------------
  // pin state control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      release_q <= 1'b0;
      pull_cnt  <= 3'h0;
    end
    else
    begin
      release_q <= s_rel;
      if (s_rel && !release_q && bus_area_config[B_ADDR_PULL])
        pull_cnt <= PULL_CYCLES;
      else if (pull_cnt != 3'h0)
        pull_cnt <= pull_cnt - 3'h1;
    end
  end

  // pull-ups
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      addr_pullup_en <= 1'b0;
      data_pullup_en <= 1'b0;
    end
    else
    begin
      addr_pullup_en <= (pull_cnt != 3'h0);
      // bus counts as idle when no access is presented
      data_pullup_en <= bus_area_config[B_DATA_PULL] &&
                        !acc_valid;
    end
  end

  // standby and release drive of the control and strobe pins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctl_pins_oe         <= 1'b1;
      ctl_pins_drive_high <= 1'b0;
      strobe_pins_oe      <= 1'b1;
    end
    else
    begin
      ctl_pins_oe    <= !s_stby ||
                        bus_area_config[B_STBY_HIGH];
      ctl_pins_drive_high <= s_stby &&
                             bus_area_config[B_STBY_HIGH];
      strobe_pins_oe <= !(s_stby || s_rel) ||
                        bus_area_config[B_STRB_KEEP];
    end
  end

  // byte order and card i/o sizing
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      little_endian <= 1'b0;
      dyn_sizing_en <= 1'b0;
    end
    else
    begin
      little_endian <= bus_area_config[B_ENDIAN];
      // io16 from the card answers the registered select, so pair it
      // with the registered card flag; big endian never sizes
      dyn_sizing_en <= bus_area_config[B_ENDIAN] && card_io16 &&
                       area_card;
    end
  end

  // strap status for software; 00 on the width straps is prohibited
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      strap_illegal <= 1'b0;
    else
      strap_illegal <= strap_taken && area0_width == 2'h0;
  end

endmodule : eba_area_config

// File: verilog/eba_pkg.sv
// eba_pkg: constants for the external bus area decoder and config block
// assumes a 32-bit apb slave port and a 20 MHz system clock
package eba_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_AREA_CFG  = 8'h00;
  localparam logic [7:0] OFS_WIDTH_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;

  localparam logic [15:0] AREA_CFG_RST  = 16'h0000;
  localparam logic [15:0] WIDTH_CFG_RST = 16'h3ff0;
  // writable bits; bit 11 is the captured byte order, read-only
  localparam logic [15:0] AREA_CFG_WMASK  = 16'hf7ff;
  localparam logic [15:0] WIDTH_CFG_WMASK = 16'h3ff0;

  // ----------------------------------------------------------------------
  // field positions in bus_area_config
  // ----------------------------------------------------------------------
  localparam int B_ADDR_PULL  = 15;
  localparam int B_DATA_PULL  = 14;
  localparam int B_STBY_HIGH  = 13;
  localparam int B_STRB_KEEP  = 12;
  localparam int B_ENDIAN     = 11;
  localparam int B_A0_BST     = 9;
  localparam int B_A5_BST     = 7;
  localparam int B_A6_BST     = 5;
  localparam int B_MEM_TYPE   = 2;
  localparam int B_A5_CARD    = 1;
  localparam int B_A6_CARD    = 0;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] MT_ORDINARY = 3'h0;
  localparam logic [2:0] MT_A3_SDRAM = 3'h2;
  localparam logic [2:0] MT_BOTH_SD  = 3'h3;

  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;

  localparam logic [2:0] AREA_NONE = 3'h1;
  localparam logic [2:0] AREA_LAST = 3'h6;

  localparam logic [2:0] PULL_CYCLES = 3'h4;

endpackage : eba_pkg
